// file: sfc_cfg_regs.sv
// Slot A front-end configuration register bank on the host register port
//
// Summary of operation
// - Channel 2..4 gain fields need individual enable
// - Four polarity bits, one per pulse, repeating
// - Window width in 1 us steps, reset 0x4
// - Window offset in 31.25 ns steps, reset 0x2fc
// - Bit 9 buffer gain: unity or 0.7
// - Bit 7 turns integrator into buffer amplifier
// - Enabled: channel 1 shared, others own fields
// - Reference select, four levels, resets to 3
// - Disabled: shared gain drives all four channels
// - Path register resets to full-path code
// - Code 0xb065 is bypass with integrator normal
`timescale 1ns/1ps
module sfc_cfg_regs (
    input  wire logic                          CLOCK,        // Core clock, 250 MHz
    input  wire logic                          RST,          // Synchronous reset, high
    input  wire logic                          CE,           // Clock enable, freezes all
    input  wire sfc_pkg::sfc_req_s             REQ,          // Host register request
    output logic [sfc_pkg::DATA_W-1:0]         RDATA,        // Read data
    output logic                               RVALID,       // Read data valid pulse
    output logic [sfc_pkg::ORDER_W-1:0]        POLARITY_ORDER, // Per-pulse polarity
    output logic [sfc_pkg::WIDTH_W-1:0]        WINDOW_WIDTH, // Window width, 1 us units
    output logic [sfc_pkg::OFFSET_W-1:0]       WINDOW_OFFSET, // Window start, 31.25 ns
    output logic                               BUFFER_GAIN_SEL, // 0 unity, 1 gain 0.7
    output logic                               INTEG_AS_BUFFER, // Integrator as buffer
    output logic [sfc_pkg::REF_W-1:0]          REFERENCE_SEL, // Reference level code
    output sfc_pkg::sfc_gains_t                CH_GAIN,      // Effective gain per channel
    output logic [sfc_pkg::DATA_W-1:0]         PATH_CODE,    // Raw path connection code
    output sfc_pkg::sfc_path_e                 PATH_MODE,    // Decoded path mode
    output logic                               PATH_CFG_ERR  // Reserved code or bad pairing
);

    // ------------------------------------------------------------
    // State of the bank
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]         order;                  // Order register image
        logic [15:0]         window;                 // Window register image
        logic [15:0]         mode;                   // Mode register image
        logic [15:0]         path;                   // Path register image
        logic [5:0]          chgain;                 // Per-channel gain image
        logic [15:0]         rdata;                  // Read data out
        logic                rvalid;                 // Read strobe echo
        sfc_pkg::sfc_gains_t gains;                  // Registered effective gains
        sfc_pkg::sfc_path_e  pmode;                  // Registered path mode
        logic                perr;                   // Registered path error
    } sfc_state_s;

    sfc_state_s          st_ff;                      // Current state
    sfc_state_s          nxt_st;                     // Next state
    sfc_pkg::sfc_gains_t nxt_gains;                  // From the gain resolver
    logic [15:0]         nxt_mode_img;               // Mode image after this edge
    logic [5:0]          nxt_chg_img;                // Per-channel image after this edge

    // ------------------------------------------------------------
    // Decoding shared by read path and path mode logic
    // ------------------------------------------------------------
    // Maps a path code to its mode
    function automatic sfc_pkg::sfc_path_e path_decode(input logic [15:0] code);
        sfc_pkg::sfc_path_e m;
        m = sfc_pkg::SFC_PATH_RESERVED;              // Unlisted codes are reserved
        case (code)
            sfc_pkg::PATH_FULL:       m = sfc_pkg::SFC_PATH_FULL;
            sfc_pkg::PATH_BYPASS_BUF: m = sfc_pkg::SFC_PATH_BYPASS_BUF;
            sfc_pkg::PATH_BYPASS:     m = sfc_pkg::SFC_PATH_BYPASS;
            default:                  m = sfc_pkg::SFC_PATH_RESERVED;
        endcase
        return m;
    endfunction : path_decode

    // Read image of an offset, zero when unmapped
    function automatic logic [15:0] read_mux(input logic [7:0] a, input sfc_state_s s);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            sfc_pkg::OFS_ORDER:  v = s.order;
            sfc_pkg::OFS_WINDOW: v = s.window;
            sfc_pkg::OFS_MODE:   v = s.mode;
            sfc_pkg::OFS_PATH:   v = s.path;
            sfc_pkg::OFS_CHGAIN: v = {10'h000, s.chgain}; // Upper bits belong elsewhere
            default:             v = 16'h0000;
        endcase
        return v;
    endfunction : read_mux

    // ------------------------------------------------------------
    // Gain resolver works on the next images so gains track writes
    // ------------------------------------------------------------
    // Images decoded apart from the state copy, so the resolver output
    // never loops back through the struct that it feeds
    always_comb begin
        nxt_mode_img = st_ff.mode;
        nxt_chg_img  = st_ff.chgain;
        if (RST) begin
            nxt_mode_img = sfc_pkg::RST_MODE;
            nxt_chg_img  = sfc_pkg::RST_CHGAIN;
        end else if (REQ.wr && (REQ.addr == sfc_pkg::OFS_MODE)) begin
            nxt_mode_img = REQ.wdata;
        end else if (REQ.wr && (REQ.addr == sfc_pkg::OFS_CHGAIN)) begin
            nxt_chg_img  = REQ.wdata[sfc_pkg::CHGAIN_W-1:0];
        end
    end

    sfc_gain_sel u_gain (
        .ind_en      (nxt_mode_img[sfc_pkg::INDEN_BIT]),
        .shared_gain (nxt_mode_img[sfc_pkg::SHGAIN_LSB +: sfc_pkg::GAIN_W]),
        .ch_gain     (nxt_chg_img),
        .gains       (nxt_gains)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = 1'b0;
        // Writes store every bit, per-channel gains [5:0] only; reserved bits stay writable, software keeps them
        if (REQ.wr) begin
            case (REQ.addr)
                sfc_pkg::OFS_ORDER:  nxt_st.order  = REQ.wdata;
                sfc_pkg::OFS_WINDOW: nxt_st.window = REQ.wdata;
                sfc_pkg::OFS_MODE:   nxt_st.mode   = REQ.wdata;
                sfc_pkg::OFS_PATH:   nxt_st.path   = REQ.wdata;
                sfc_pkg::OFS_CHGAIN: nxt_st.chgain = REQ.wdata[sfc_pkg::CHGAIN_W-1:0];
                default:             nxt_st.order  = st_ff.order; // Unmapped write ignored
            endcase
        end
        // Read returns the image before any same-cycle write
        if (REQ.rd) begin
            nxt_st.rdata  = read_mux(REQ.addr, st_ff);
            nxt_st.rvalid = 1'b1;
        end
        nxt_st.gains = nxt_gains;
        nxt_st.pmode = path_decode(nxt_st.path);
        // Flags the buffered bypass without the buffer bit, or a reserved code
        nxt_st.perr  = (nxt_st.pmode == sfc_pkg::SFC_PATH_RESERVED) ||
                       ((nxt_st.pmode == sfc_pkg::SFC_PATH_BYPASS_BUF) &&
                        !nxt_st.mode[sfc_pkg::INTBUF_BIT]);
        if (RST) begin
            nxt_st        = '0;
            nxt_st.order  = sfc_pkg::RST_ORDER;
            nxt_st.window = sfc_pkg::RST_WINDOW;
            nxt_st.mode   = sfc_pkg::RST_MODE;
            nxt_st.path   = sfc_pkg::RST_PATH;
            nxt_st.chgain = sfc_pkg::RST_CHGAIN;
            nxt_st.pmode  = sfc_pkg::SFC_PATH_FULL;
        end
    end

    // ------------------------------------------------------------
    // State register; reset also needs CE, as everything freezes
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (CE) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from the state flops
    // ------------------------------------------------------------
    assign RDATA           = st_ff.rdata;
    assign RVALID          = st_ff.rvalid;
    assign POLARITY_ORDER  = st_ff.order[sfc_pkg::ORDER_LSB +: sfc_pkg::ORDER_W];
    assign WINDOW_WIDTH    = st_ff.window[sfc_pkg::WIDTH_LSB +: sfc_pkg::WIDTH_W];
    assign WINDOW_OFFSET   = st_ff.window[sfc_pkg::OFFSET_LSB +: sfc_pkg::OFFSET_W];
    assign BUFFER_GAIN_SEL = st_ff.mode[sfc_pkg::BUFG_BIT];
    assign INTEG_AS_BUFFER = st_ff.mode[sfc_pkg::INTBUF_BIT];
    assign REFERENCE_SEL   = st_ff.mode[sfc_pkg::REF_LSB +: sfc_pkg::REF_W];
    assign CH_GAIN         = st_ff.gains;
    assign PATH_CODE       = st_ff.path;
    assign PATH_MODE       = st_ff.pmode;
    assign PATH_CFG_ERR    = st_ff.perr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_write(logic [7:0] a);
        CE && !RST && REQ.wr && (REQ.addr == a);
    endsequence

    sequence s_reset_done;
        CE && RST ##1 !RST;
    endsequence

    a_order_write: assert property (@(posedge CLOCK) disable iff (RST)
        s_write(sfc_pkg::OFS_ORDER) |=>
            (POLARITY_ORDER == $past(REQ.wdata[sfc_pkg::ORDER_LSB +: sfc_pkg::ORDER_W])))
        else $error("Polarity order not taken from write");

    a_width_write: assert property (@(posedge CLOCK) disable iff (RST)
        s_write(sfc_pkg::OFS_WINDOW) |=>
            (WINDOW_WIDTH == $past(REQ.wdata[sfc_pkg::WIDTH_LSB +: sfc_pkg::WIDTH_W])) &&
            (WINDOW_OFFSET == $past(REQ.wdata[sfc_pkg::OFFSET_LSB +: sfc_pkg::OFFSET_W])))
        else $error("Window fields not taken from write");

    a_window_reset: assert property (@(posedge CLOCK)
        s_reset_done |->
            (WINDOW_WIDTH == sfc_pkg::RST_WINDOW[sfc_pkg::WIDTH_LSB +: sfc_pkg::WIDTH_W]) &&
            (WINDOW_OFFSET == sfc_pkg::RST_WINDOW[sfc_pkg::OFFSET_LSB +: sfc_pkg::OFFSET_W]))
        else $error("Window reset values wrong");

    a_ref_reset: assert property (@(posedge CLOCK)
        s_reset_done |-> (REFERENCE_SEL == sfc_pkg::RST_MODE[sfc_pkg::REF_LSB +: sfc_pkg::REF_W]) &&
            !BUFFER_GAIN_SEL && !INTEG_AS_BUFFER)
        else $error("Mode reset values wrong");

    a_path_reset: assert property (@(posedge CLOCK)
        s_reset_done |-> (PATH_CODE == sfc_pkg::RST_PATH) && (PATH_MODE == sfc_pkg::SFC_PATH_FULL))
        else $error("Path reset value wrong");

    a_mode_bits: assert property (@(posedge CLOCK) disable iff (RST)
        s_write(sfc_pkg::OFS_MODE) |=>
            (BUFFER_GAIN_SEL == $past(REQ.wdata[sfc_pkg::BUFG_BIT])) &&
            (INTEG_AS_BUFFER == $past(REQ.wdata[sfc_pkg::INTBUF_BIT])))
        else $error("Buffer control bits not taken");

    a_shared_gain: assert property (@(posedge CLOCK) disable iff (RST)
        !st_ff.mode[sfc_pkg::INDEN_BIT] |-> (CH_GAIN[3] == CH_GAIN[0]) &&
            (CH_GAIN[2] == CH_GAIN[0]) && (CH_GAIN[1] == CH_GAIN[0]) &&
            (CH_GAIN[0] == st_ff.mode[sfc_pkg::SHGAIN_LSB +: sfc_pkg::GAIN_W]))
        else $error("Shared gain not on all channels");

    a_indiv_gain: assert property (@(posedge CLOCK) disable iff (RST)
        st_ff.mode[sfc_pkg::INDEN_BIT] |-> (CH_GAIN[3] == st_ff.chgain[5:4]) &&
            (CH_GAIN[2] == st_ff.chgain[3:2]) && (CH_GAIN[1] == st_ff.chgain[1:0]) &&
            (CH_GAIN[0] == st_ff.mode[sfc_pkg::SHGAIN_LSB +: sfc_pkg::GAIN_W]))
        else $error("Individual gains not routed");

    a_bypass_plain: assert property (@(posedge CLOCK) disable iff (RST)
        s_write(sfc_pkg::OFS_PATH) ##0 (REQ.wdata == sfc_pkg::PATH_BYPASS) |=>
            (PATH_MODE == sfc_pkg::SFC_PATH_BYPASS) && !PATH_CFG_ERR)
        else $error("Plain bypass code not decoded");

    a_bypass_pair: assert property (@(posedge CLOCK) disable iff (RST)
        (PATH_MODE == sfc_pkg::SFC_PATH_BYPASS_BUF) && !INTEG_AS_BUFFER |-> PATH_CFG_ERR)
        else $error("Buffered bypass without buffer bit not flagged");

    a_read_latency: assert property (@(posedge CLOCK) disable iff (RST)
        CE && REQ.rd && (REQ.addr == sfc_pkg::OFS_CHGAIN) |=>
            RVALID && (RDATA == {10'h000, $past(st_ff.chgain)}))
        else $error("Gain register read wrong");

endmodule : sfc_cfg_regs

// file: sfc_gain_sel.sv
// Resolves the effective gain code of each slot A channel
`timescale 1ns/1ps
module sfc_gain_sel (
    input  wire logic                      ind_en,     // Per-channel selection enabled
    input  wire logic [sfc_pkg::GAIN_W-1:0] shared_gain, // Shared code, channel 1 always
    input  wire logic [sfc_pkg::CHGAIN_W-1:0] ch_gain, // Channels 2..4, two bits each
    output sfc_pkg::sfc_gains_t            gains       // Effective code per channel
);

    // ------------------------------------------------------------
    // Channel 1 never has a field of its own
    // ------------------------------------------------------------
    assign gains[0] = shared_gain;

    // ------------------------------------------------------------
    // Channels 2..4: own field only when enabled
    // ------------------------------------------------------------
    for (genvar g = 1; g < sfc_pkg::NUM_CH; g++) begin : g_ch
        assign gains[g] = ind_en ? ch_gain[(g-1)*sfc_pkg::GAIN_W +: sfc_pkg::GAIN_W]
                                 : shared_gain;
    end

endmodule : sfc_gain_sel

// file: sfc_pkg.sv
// Shared constants and types of the slot A front-end configuration bank
package sfc_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;                        // Host register address width
    localparam int DATA_W = 16;                       // Host register data width
    localparam int NUM_CH = 4;                        // Channels in the slot
    localparam int GAIN_W = 2;                        // Gain code width

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ORDER  = 8'h17;        // Integration order
    localparam logic [7:0] OFS_WINDOW = 8'h39;        // Window width and offset
    localparam logic [7:0] OFS_MODE   = 8'h42;        // Front-end mode
    localparam logic [7:0] OFS_PATH   = 8'h43;        // Path connection
    localparam logic [7:0] OFS_CHGAIN = 8'h55;        // Per-channel gains

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ORDER  = 16'h0000;    // All pulses normal
    localparam logic [15:0] RST_WINDOW = 16'h22fc;    // Width 0x4, offset 0x2fc
    localparam logic [15:0] RST_MODE   = 16'h1c38;    // Mode 0x07, ref 0x3, rsvd 0x2
    localparam logic [15:0] RST_PATH   = 16'hada5;    // Full path
    localparam logic [5:0]  RST_CHGAIN = 6'h00;       // Channels 2..4 at 200k

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ORDER_LSB  = 0;                    // Polarity order [3:0]
    localparam int ORDER_W    = 4;
    localparam int WIDTH_LSB  = 11;                   // Window width [15:11]
    localparam int WIDTH_W    = 5;
    localparam int OFFSET_LSB = 0;                    // Window offset [10:0]
    localparam int OFFSET_W   = 11;
    localparam int BUFG_BIT   = 9;                    // Buffer gain select
    localparam int INTBUF_BIT = 7;                    // Integrator as buffer
    localparam int INDEN_BIT  = 6;                    // Per-channel gain enable
    localparam int REF_LSB    = 4;                    // Reference select [5:4]
    localparam int REF_W      = 2;
    localparam int SHGAIN_LSB = 0;                    // Shared gain [1:0]
    localparam int CHGAIN_W   = 6;                    // Per-channel field [5:0]

    // ------------------------------------------------------------
    // Path codes
    // ------------------------------------------------------------
    localparam logic [15:0] PATH_FULL       = 16'hada5; // Amp, filter, integrator, converter
    localparam logic [15:0] PATH_BYPASS_BUF = 16'hae65; // Bypass, integrator as buffer
    localparam logic [15:0] PATH_BYPASS     = 16'hb065; // Bypass, integrator normal

    // Decoded signal-path mode
    typedef enum logic [1:0] {
        SFC_PATH_FULL       = 2'b00,
        SFC_PATH_BYPASS_BUF = 2'b01,
        SFC_PATH_BYPASS     = 2'b10,
        SFC_PATH_RESERVED   = 2'b11
    } sfc_path_e;

    // One gain code per channel, index 0 is channel 1
    typedef logic [NUM_CH-1:0][GAIN_W-1:0] sfc_gains_t;

    // Host register request bundle
    typedef struct packed {
        logic              wr;                        // Write strobe
        logic              rd;                        // Read strobe
        logic [ADDR_W-1:0] addr;                      // Register offset
        logic [DATA_W-1:0] wdata;                     // Write data
    } sfc_req_s;

endpackage : sfc_pkg

// file: testbench.sv
// Self-checking testbench for the slot A front-end configuration bank
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                clk;         // Core clock, 4 ns period
    logic                rst;         // Synchronous reset, high
    logic                ce;          // Clock enable
    sfc_pkg::sfc_req_s   req;         // Host register request
    logic [15:0]         rdata;       // Read data
    logic                rvalid;      // Read data valid
    logic [3:0]          pol;         // Polarity order
    logic [4:0]          wid;         // Window width
    logic [10:0]         ofs;         // Window offset
    logic                bufg;        // Buffer gain select
    logic                intbuf;      // Integrator as buffer
    logic [1:0]          refsel;      // Reference select
    sfc_pkg::sfc_gains_t gains;       // Effective channel gains
    logic [15:0]         pcode;       // Path code image
    sfc_pkg::sfc_path_e  pmode;       // Decoded path mode
    logic                perr;        // Path configuration flag
    int                  mismatches;  // Failed comparisons
    int                  num_checks;  // Comparisons made
    // Mode value software must use: mode field 0x07, reserved bits 0x1
    localparam logic [15:0] MODE_BASE = 16'h1c04;

    sfc_cfg_regs dut_u (.CLOCK(clk), .RST(rst), .CE(ce), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
        .POLARITY_ORDER(pol), .WINDOW_WIDTH(wid), .WINDOW_OFFSET(ofs), .BUFFER_GAIN_SEL(bufg),
        .INTEG_AS_BUFFER(intbuf), .REFERENCE_SEL(refsel), .CH_GAIN(gains), .PATH_CODE(pcode),
        .PATH_MODE(pmode), .PATH_CFG_ERR(perr));

    // Free-running clock
    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare with case equality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One-cycle write strobe, inputs move 1 ns after the edge; an idle
    // edge first, so a strobe is never dropped and raised in one step
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask : wr_reg

    // Read strobe; answer is settled one edge later
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        #1 req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1 req.rd = 1'b0;
        chk({15'h0, rvalid}, 16'h1, "read valid");
        chk(rdata, exp, "read data");
    endtask : rd_reg

    // Verdict and end of run, also reached by the watchdog
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset image of every register but 0x55, and the path, mode and gain outputs
    task automatic t_reset();
        rd_reg(8'h39, {5'h04, 11'h2fc});
        rd_reg(8'h43, 16'hada5);
        rd_reg(8'h17, 16'h0000);
        rd_reg(8'h42, 16'h1c38);
        chk(pcode, 16'hada5, "path code reset");
        chk({14'h0, bufg, intbuf}, 16'h0, "buffer bits reset");
        chk({14'h0, refsel}, 16'h3, "reference reset");
        chk({14'h0, pmode}, 16'h0, "path mode reset");
        chk({8'h0, gains}, 16'h0, "gain reset");
    endtask : t_reset

    // Field boundaries of the window register, back to back
    task automatic t_window();
        wr_reg(8'h39, 16'hffff);
        chk({11'h0, wid}, 16'h1f, "width max");
        chk({5'h0, ofs}, 16'h7ff, "offset max");
        wr_reg(8'h39, {5'h01, 11'h001});
        chk({11'h0, wid}, 16'h01, "width min");
        chk({5'h0, ofs}, 16'h001, "offset min");
    endtask : t_window

    // Each pulse's polarity bit lands in its own position
    task automatic t_order();
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h17, 16'h1 << i);
            chk({12'h0, pol}, 16'h1 << i, "polarity order");
        end
    endtask : t_order

    // Every reference and shared gain code, buffer bits
    task automatic t_mode();
        for (int r = 0; r < 4; r++) begin
            for (int g = 0; g < 4; g++) begin
                wr_reg(8'h42, MODE_BASE | 16'(r << 4) | 16'(g));
                chk({14'h0, refsel}, 16'(r), "reference sel");
                chk({8'h0, gains}, {8'h0, 2'(g), 2'(g), 2'(g), 2'(g)}, "shared gain");
            end
        end
        wr_reg(8'h42, MODE_BASE | 16'h0280);
        chk({14'h0, bufg, intbuf}, 16'h3, "buffer bits set");
        wr_reg(8'h42, MODE_BASE);
        chk({14'h0, bufg, intbuf}, 16'h0, "buffer bits clear");
    endtask : t_mode

    // Per-channel gains only count while the enable is set
    task automatic t_indiv();
        wr_reg(8'h55, 16'hffff);
        rd_reg(8'h55, 16'h003f);
        wr_reg(8'h55, 16'h0039);
        chk({8'h0, gains}, 16'h0, "gain fields ignored");
        wr_reg(8'h42, MODE_BASE | 16'h0040);
        chk({8'h0, gains}, {8'h0, 2'd3, 2'd2, 2'd1, 2'd0}, "individual gains");
        wr_reg(8'h42, MODE_BASE | 16'h0042);
        chk({8'h0, gains}, {8'h0, 2'd3, 2'd2, 2'd1, 2'd2}, "channel 1 shared");
        wr_reg(8'h42, MODE_BASE);
        chk({8'h0, gains}, 16'h0, "individual off");
    endtask : t_indiv

    // All path codes, the pairing with bit 7 and a reserved code
    task automatic t_path();
        wr_reg(8'h43, 16'hae65);
        chk({13'h0, pmode, perr}, 16'h3, "buffered bypass unpaired");
        wr_reg(8'h42, MODE_BASE | 16'h0080);
        chk({13'h0, pmode, perr}, 16'h2, "buffered bypass paired");
        wr_reg(8'h42, MODE_BASE);
        wr_reg(8'h43, 16'hb065);
        chk({13'h0, pmode, perr}, 16'h4, "plain bypass");
        wr_reg(8'h43, 16'h1234);
        chk({13'h0, pmode, perr}, 16'h7, "reserved code");
        chk(pcode, 16'h1234, "path code image");
        rd_reg(8'h43, 16'h1234);
        wr_reg(8'h43, 16'hada5);
        chk({13'h0, pmode, perr}, 16'h0, "full path");
    endtask : t_path

    // Unmapped read and a write while the clock enable is low
    task automatic t_refuse();
        rd_reg(8'h00, 16'h0000);
        ce = 1'b0;
        wr_reg(8'h39, 16'hffff);
        ce = 1'b1;
        rd_reg(8'h39, {5'h01, 11'h001});
    endtask : t_refuse

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        mismatches = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_window();
        t_order();
        t_mode();
        t_indiv();
        t_path();
        t_refuse();
        print_verdict();
    end

    // Whole run needs under a hundred cycles; far margin before cutting
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : testbench
